// file: powerdown_control_logic.sv
// power-down control logic with an axi4-lite register slave
`timescale 1ns/1ps
`include "pwrdn_consts.svh"

module powerdown_control_logic
    import pwrdn_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        external_powerdown_pin,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             digital_powerdown,
    output logic             dac_powerdown,
    output logic             input_clock_powerdown,
    output logic             pll_powerdown
);

    logic [31:0] first_control_function_word;
    logic        pin_meta;
    logic        pin_sync;
    pd_mode_t    mode;
    logic        aw_held;
    logic        w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        next_digital;
    logic        next_dac;
    logic        next_clkin;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // only writable word, low page only
    function automatic logic is_ctrl_word(input logic [31:0] addr);
        return (addr[31:8] == 24'h00_0000) && (addr[7:2] == 6'(`CTRL_WORD_OFFSET >> 2));
    endfunction : is_ctrl_word

    // two-stage pin synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= external_powerdown_pin;
            pin_sync <= pin_meta;
        end
    end

    always_comb begin
        if (!pin_sync) begin
            mode = MODE_SOFTWARE;
        end else if (first_control_function_word[`BIT_MODE_SELECT]) begin
            mode = MODE_FULL_POWERDOWN;
        end else begin
            mode = MODE_FAST_RECOVERY;
        end
    end

    always_comb begin
        case (mode)
            MODE_SOFTWARE: begin
                next_digital = first_control_function_word[`BIT_DIGITAL_PD];
                next_dac     = first_control_function_word[`BIT_DAC_PD];
                next_clkin   = first_control_function_word[`BIT_CLKIN_PD];
            end
            MODE_FAST_RECOVERY: begin
                next_digital = 1'b1;
                next_dac     = 1'b0;
                next_clkin   = 1'b0;
            end
            default: begin
                next_digital = 1'b1;
                next_dac     = 1'b1;
                next_clkin   = 1'b1;
            end
        endcase
    end

    // registered active-high power-down outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            digital_powerdown     <= 1'b0;
            dac_powerdown         <= 1'b0;
            input_clock_powerdown <= 1'b0;
            pll_powerdown         <= 1'b0;
        end else begin
            digital_powerdown     <= next_digital;
            dac_powerdown         <= next_dac;
            input_clock_powerdown <= next_clkin;
            pll_powerdown         <= first_control_function_word[`BIT_PLL_PD];
        end
    end

    // write channel capture, address and data in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else if (aw_held && w_held) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_control_function_word <= `CTRL_WORD_RESET;
        end else if (aw_held && w_held && is_ctrl_word(aw_addr)) begin
            first_control_function_word <= merge_bytes(first_control_function_word, w_data, w_strb)
                                           & `CTRL_WORD_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (aw_held && w_held) begin
            s_axi_bvalid <= 1'b1;
            if (is_ctrl_word(aw_addr)) begin
                s_axi_bresp <= `RESP_OKAY;
            end else begin
                s_axi_bresp <= `RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            if (s_axi_araddr[31:8] != 24'h00_0000) begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `RESP_SLVERR;
            end else if (s_axi_araddr[7:2] == 6'(`CTRL_WORD_OFFSET >> 2)) begin
                s_axi_rdata <= first_control_function_word;
            end else if (s_axi_araddr[7:2] == 6'(`STATUS_OFFSET >> 2)) begin
                s_axi_rdata <= {25'h0, 2'(mode), pin_sync, pll_powerdown,
                                input_clock_powerdown, dac_powerdown, digital_powerdown};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    a_fast_recovery_out: assert property (@(posedge aclk) disable iff (!aresetn)
        (pin_sync && !first_control_function_word[`BIT_MODE_SELECT])
        |=> (digital_powerdown && !dac_powerdown && !input_clock_powerdown))
        else $error("fast recovery outputs wrong");
    a_full_powerdown_out: assert property (@(posedge aclk) disable iff (!aresetn)
        (pin_sync && first_control_function_word[`BIT_MODE_SELECT])
        |=> (digital_powerdown && dac_powerdown && input_clock_powerdown))
        else $error("full power-down outputs wrong");
    a_software_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        !pin_sync |=> (digital_powerdown == $past(first_control_function_word[`BIT_DIGITAL_PD])
        && dac_powerdown == $past(first_control_function_word[`BIT_DAC_PD])
        && input_clock_powerdown == $past(first_control_function_word[`BIT_CLKIN_PD])))
        else $error("software mode outputs do not follow bits");
    a_pll_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 pll_powerdown == $past(first_control_function_word[`BIT_PLL_PD]))
        else $error("pll power-down does not follow its bit");
    a_pin_latency: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(external_powerdown_pin) ##1 external_powerdown_pin |=> pin_sync)
        else $error("pin not synchronised in two cycles");
    a_pin_high_ignores: assert property (@(posedge aclk) disable iff (!aresetn)
        (pin_sync && $past(pin_sync) && $stable(first_control_function_word[`BIT_MODE_SELECT]))
        |=> $stable(digital_powerdown) && $stable(dac_powerdown) && $stable(input_clock_powerdown))
        else $error("outputs moved while pin held high");
    a_bresp_pairs: assert property (@(posedge aclk) disable iff (!aresetn)
        (aw_held && w_held) |=> s_axi_bvalid && !aw_held && !w_held)
        else $error("write response missing");
    a_fast_keeps_clock: assert property (@(posedge aclk) disable iff (!aresetn)
        (mode == MODE_FAST_RECOVERY) ##1 (mode == MODE_FAST_RECOVERY) |-> !input_clock_powerdown)
        else $error("clock input powered down in fast recovery");

endmodule : powerdown_control_logic

// file: pwrdn_consts.svh
// offsets, field positions and reset values for the power-down control block
`ifndef PWRDN_CONSTS_SVH
`define PWRDN_CONSTS_SVH

`define CTRL_WORD_OFFSET   32'h0000_0000
`define STATUS_OFFSET      32'h0000_0004
`define CTRL_WORD_RESET    32'h0000_0000
`define BIT_DIGITAL_PD     7
`define BIT_PLL_PD         6
`define BIT_DAC_PD         5
`define BIT_CLKIN_PD       4
`define BIT_MODE_SELECT    3
`define CTRL_WORD_MASK     32'h0000_00f8
`define STAT_BIT_DIGITAL   0
`define STAT_BIT_DAC       1
`define STAT_BIT_CLKIN     2
`define STAT_BIT_PLL       3
`define STAT_BIT_PIN       4
`define STAT_MODE_LSB      5
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

// file: pwrdn_pkg.sv
// types for the power-down control block
package pwrdn_pkg;
    typedef enum logic [1:0] {
        MODE_SOFTWARE,
        MODE_FAST_RECOVERY,
        MODE_FULL_POWERDOWN
    } pd_mode_t;
endpackage : pwrdn_pkg

// file: pd_host_model.sv
// host-side model that drives the external power-down pin
`timescale 1ns/1ps
module pd_host_model (
    input  wire logic aclk,
    input  wire logic want_pin,
    output logic      external_powerdown_pin
);
    // plain level from host logic, moved just after an edge
    always_ff @(posedge aclk) begin
        external_powerdown_pin <= want_pin;
    end
endmodule : pd_host_model

// file: tb_top.sv
// self-checking bench for the power-down control block
`timescale 1ns/1ps
`include "pwrdn_consts.svh"
module tb_top;
    import pwrdn_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        want_pin = 1'b0;
    logic        pin;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        dig, dac, clk_pd, pll;
    logic [33:0] rq[$];
    logic [1:0]  wq[$];
    logic [33:0] r;
    logic [1:0]  b;
    logic [31:0] seed = 32'h490a247e, d, e;
    int          bad_count = 0, num_checks = 0;

    always #25 aclk = ~aclk;

    pd_host_model u_host (.aclk(aclk), .want_pin(want_pin), .external_powerdown_pin(pin));

    powerdown_control_logic u_dut (
        .aclk(aclk), .aresetn(aresetn), .external_powerdown_pin(pin),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .digital_powerdown(dig),
        .dac_powerdown(dac), .input_clock_powerdown(clk_pd), .pll_powerdown(pll)
    );

    function automatic logic [31:0] lfsr_next(logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h0400_0007 : 32'h0);
    endfunction : lfsr_next

    // status image: {mode, pin, pll, clock, dac, digital}
    function automatic logic [31:0] stat_exp(logic p, logic [31:0] c);
        logic [3:0] o;
        logic [1:0] m;
        o = p ? {c[6], c[3], c[3], 1'b1} : {c[6], c[4], c[5], c[7]};
        m = p ? (c[3] ? 2'(MODE_FULL_POWERDOWN) : 2'(MODE_FAST_RECOVERY)) : 2'(MODE_SOFTWARE);
        return {25'h0, m, p, o};
    endfunction : stat_exp

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    task automatic axi_write(logic [31:0] a, logic [31:0] v, logic [1:0] er);
        int n;
        n = 0;
        wq.push_back(er);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
        s_axi_bready <= 1'b0;
        if (n >= 100) begin
            bad_count++;
            finish_test();
        end
    endtask : axi_write

    task automatic axi_read(logic [31:0] a, logic [31:0] ev, logic [1:0] er);
        int n;
        n = 0;
        rq.push_back({er, ev});
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
        s_axi_rready <= 1'b0;
        if (n >= 100) begin
            bad_count++;
            finish_test();
        end
    endtask : axi_read

    // response watcher: oldest note against each answer
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
            r = rq.pop_front();
            check("rresp", {30'h0, s_axi_rresp}, {30'h0, r[33:32]});
            check("rdata", s_axi_rdata, r[31:0]);
        end
        if (s_axi_bvalid && s_axi_bready && wq.size() > 0) begin
            b = wq.pop_front();
            check("bresp", {30'h0, s_axi_bresp}, {30'h0, b});
        end
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`CTRL_WORD_OFFSET, `CTRL_WORD_RESET, `RESP_OKAY);
        check("reset outputs", {28'h0, pll, clk_pd, dac, dig}, 32'h0000_0000);
        // every pin level against both mode-select values, other bits random
        for (int i = 0; i < 24; i++) begin
            seed = lfsr_next(seed);
            d = {seed[31:4], i[1], seed[2:0]};
            e = stat_exp(i[0], d);
            want_pin <= i[0];
            axi_write(`CTRL_WORD_OFFSET, d, `RESP_OKAY);
            repeat (5) @(posedge aclk);
            check("outputs", {28'h0, pll, clk_pd, dac, dig}, {28'h0, e[3:0]});
            axi_read(`STATUS_OFFSET, e, `RESP_OKAY);
            axi_read(`CTRL_WORD_OFFSET, d & `CTRL_WORD_MASK, `RESP_OKAY);
        end
        axi_write(32'h0000_0008, 32'hffff_ffff, `RESP_SLVERR);
        axi_write(`STATUS_OFFSET, 32'hffff_ffff, `RESP_SLVERR);
        axi_read(32'h0000_0008, 32'h0, `RESP_SLVERR);
        axi_read(`CTRL_WORD_OFFSET, d & `CTRL_WORD_MASK, `RESP_OKAY);
        // low byte lane masked off: control bits must keep their value
        s_axi_wstrb <= 4'he;
        axi_write(`CTRL_WORD_OFFSET, 32'hffff_ff00, `RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        axi_read(`CTRL_WORD_OFFSET, d & `CTRL_WORD_MASK, `RESP_OKAY);
        finish_test();
    end
endmodule : tb_top
